// >>> rtl/stl_maint.sv
// Line maintenance: threshold alerts, event log, facility loopback, error insertion
// Overview of operation
// - Alert when count reaches threshold in period
// - Alert reporting disabled after reset
// - Per-entity select default or custom threshold
// - FIFO log of 500, oldest displaced
// - Log read in pages of fifty
// - Clear command empties the log
// - Loopback sends AIS and Idle to clients
// - Terminal loopback refused, facility only
// - Loopback start sets active and testing
// - Admin enable/disable ends loopback, restores
// - One insertion selector per layer
// - B1 insertion corrupts B1 every frame
// - LOF insertion corrupts A1 A2 bytes
// - B2 insertion corrupts B2 every frame
// - MS-AIS sent continuously while selected, outside loopback
//
// The strobed register port and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
module stl_maint #(
  parameter longint unsigned P15_CYC = stl_pkg::STL_P15_CYC,
  parameter longint unsigned P24_CYC = stl_pkg::STL_P24_CYC,
  parameter int unsigned LOG_DEPTH = stl_pkg::STL_LOG_DEPTH,
  parameter int unsigned PAGE_LEN = stl_pkg::STL_PAGE_LEN
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  output logic irq,
  input wire logic [5:0] ev_pulse,
  input wire logic [2:0] ev_entity,
  input wire logic [7:0] rx_byte,
  input wire logic [7:0] gen_byte,
  input wire logic byte_a1,
  input wire logic byte_a2,
  input wire logic byte_b1,
  input wire logic byte_b2,
  output logic [7:0] tx_byte,
  output logic ms_ais_tx,
  output logic client_ais,
  output logic eth_idle,
  output logic lb_active,
  output logic [1:0] adm_state
);
  import stl_pkg::*;
  localparam int unsigned LW = $clog2(LOG_DEPTH + 1);
  localparam int unsigned NE = 8;

  logic [3:0] tca_en_r;
  logic [31:0] def_thr_r [STL_NCLASS];
  logic [31:0] cus_thr_r [NE];
  logic [NE-1:0] sel_r;
  logic [31:0] cnt15_r [STL_NCLASS];
  logic [31:0] cnt24_r [STL_NCLASS];
  logic [STL_NCLASS-1:0] hit15_r, hit24_r;
  logic [63:0] tmr15_r, tmr24_r;
  logic end15, end24;
  logic [STL_NCLASS-1:0] alert;
  logic [15:0] log_mem [LOG_DEPTH];
  logic [LW-1:0] wp_r, rp_r, cnt_r, page_r;
  logic [2:0] irq_stat_r, irq_mask_r;
  stl_rs_t rs_r;
  stl_ms_t ms_r;
  stl_adm_t adm_r;
  logic lb_r, term_rej;
  logic [31:0] rdata_r;
  logic log_push, log_clr, log_full;

  // Layer map: classes 0 RS, 1 MS, 2 VC-4, 3 VC-3, 4 VC-12, 5 pointer_adjust_count
  function automatic logic layer_on(input int unsigned c, input logic [3:0] en);
    logic r;
    r = 1'b0;
    unique case (c)
      0: r = en[0];
      1: r = en[1];
      2: r = en[2];
      3, 4: r = en[3];
      default: r = en[2] | en[3];
    endcase
    return r;
  endfunction : layer_on

  // Period timers
  assign end15 = (tmr15_r == P15_CYC - 1);
  assign end24 = (tmr24_r == P24_CYC - 1);
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      tmr15_r <= '0;
      tmr24_r <= '0;
    end
    else
    begin
      tmr15_r <= end15 ? '0 : tmr15_r + 64'd1;
      tmr24_r <= end24 ? '0 : tmr24_r + 64'd1;
    end
  end

  // Counters and threshold comparisons per class
  for (genvar c = 0; c < STL_NCLASS; c++)
  begin : g_cls
    logic [31:0] thr;
    logic [NE-1:0] ent_sel;
    assign ent_sel = sel_r;
    // Selected entity of the event picks its threshold
    assign thr = ent_sel[ev_entity] ? cus_thr_r[ev_entity] : def_thr_r[c];
    always_ff @(posedge clk)
    begin
      if (!rst_n)
      begin
        cnt15_r[c] <= '0;
        cnt24_r[c] <= '0;
        hit15_r[c] <= 1'b0;
        hit24_r[c] <= 1'b0;
      end
      else
      begin
        cnt15_r[c] <= end15 ? '0 : cnt15_r[c] + {31'h0, ev_pulse[c]};
        cnt24_r[c] <= end24 ? '0 : cnt24_r[c] + {31'h0, ev_pulse[c]};
        hit15_r[c] <= end15 ? 1'b0 : (hit15_r[c] | alert[c]);
        hit24_r[c] <= end24 ? 1'b0 : (hit24_r[c] | alert[c]);
      end
    end
    // One alert per period, only while the layer is enabled
    assign alert[c] = layer_on(c, tca_en_r) & ev_pulse[c] &
      ((!hit15_r[c] && cnt15_r[c] + 32'd1 >= thr) ||
       (!hit24_r[c] && cnt24_r[c] + 32'd1 >= thr));
  end

  // Event log: lowest class wins when several alert together
  logic [2:0] al_cls;
  always_comb
  begin
    al_cls = 3'h0;
    for (int i = STL_NCLASS - 1; i >= 0; i--)
      if (alert[i])
        al_cls = 3'(i);
  end
  assign log_push = |alert;
  assign log_clr = wr && addr == STL_REG_LOG_CTRL && wdata[STL_LOG_CLR];
  assign log_full = (cnt_r == LW'(LOG_DEPTH));
  logic pop;
  assign pop = wr && addr == STL_REG_LOG_CTRL && wdata[STL_LOG_POP] && cnt_r != '0;
  // Read pointer one and two steps on, wrapping at the log depth
  logic [LW-1:0] rp_inc1, rp_inc2;
  assign rp_inc1 = (rp_r == LW'(LOG_DEPTH - 1)) ? '0 : rp_r + 1'b1;
  assign rp_inc2 = (rp_inc1 == LW'(LOG_DEPTH - 1)) ? '0 : rp_inc1 + 1'b1;

  always_ff @(posedge clk)
  begin
    if (log_push)
      log_mem[wp_r] <= {5'h0, ev_entity, 5'h0, al_cls};
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n || log_clr)
    begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end
    else
    begin
      if (log_push)
        wp_r <= (wp_r == LW'(LOG_DEPTH - 1)) ? '0 : wp_r + 1'b1;
      // Pop beside a displacing push drops two entries from the tail
      if (pop && log_push && log_full)
        rp_r <= rp_inc2;
      else if (pop || (log_push && log_full))
        rp_r <= rp_inc1;
      if (log_push && !log_full && !pop)
        cnt_r <= cnt_r + 1'b1;
      else if (pop && !(log_push && !log_full))
        cnt_r <= cnt_r - 1'b1;
    end
  end

  // Page 0 holds the newest entries; prev steps older, next steps newer
  always_ff @(posedge clk)
  begin
    if (!rst_n || log_clr)
      page_r <= '0;
    else if (wr && addr == STL_REG_LOG_CTRL && wdata[STL_LOG_PREV] &&
             (page_r + 1'b1) * LW'(PAGE_LEN) < cnt_r)
      page_r <= page_r + 1'b1;
    else if (wr && addr == STL_REG_LOG_CTRL && wdata[STL_LOG_NEXT] && page_r != '0)
      page_r <= page_r - 1'b1;
  end

  // Entry k of the current page, counted back from the newest
  logic [LW-1:0] age, idx;
  logic [LW:0] pos;
  always_comb
  begin
    age = page_r * LW'(PAGE_LEN) + {2'b0, wdata[LW-3:0]};
    pos = {1'b0, wp_r} + (LW+1)'(LOG_DEPTH) - {1'b0, age} - 1'b1;
    idx = (pos >= (LW+1)'(LOG_DEPTH)) ? LW'(pos - (LW+1)'(LOG_DEPTH)) : pos[LW-1:0];
  end

  // Control registers
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      tca_en_r <= STL_RST_TCA_EN;
      sel_r <= '0;
      irq_mask_r <= '0;
      rs_r <= STL_RS_OFF;
      ms_r <= STL_MS_OFF;
      for (int i = 0; i < STL_NCLASS; i++)
        def_thr_r[i] <= STL_RST_THR;
      for (int i = 0; i < NE; i++)
        cus_thr_r[i] <= STL_RST_THR;
    end
    else if (wr)
    begin
      if (addr == STL_REG_TCA_EN)
        tca_en_r <= wdata[3:0];
      if (addr == STL_REG_SEL)
        sel_r <= wdata[NE-1:0];
      if (addr == STL_REG_IRQ_MASK)
        irq_mask_r <= wdata[2:0];
      if (addr == STL_REG_ERRINS)
      begin
        // Illegal code 3 leaves the selector off
        rs_r <= (wdata[1:0] == 2'h3) ? STL_RS_OFF : stl_rs_t'(wdata[1:0]);
        ms_r <= (wdata[5:4] == 2'h3) ? STL_MS_OFF : stl_ms_t'(wdata[5:4]);
      end
      for (int i = 0; i < STL_NCLASS; i++)
        if (addr == STL_REG_DEF_BASE + 8'(4 * i))
          def_thr_r[i] <= wdata;
      for (int i = 0; i < NE; i++)
        if (addr == STL_REG_CUS_BASE + 8'(4 * i))
          cus_thr_r[i] <= wdata;
    end
  end

  // Loopback control
  assign term_rej = wr && addr == STL_REG_PORT && wdata[STL_PORT_TERM];
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      lb_r <= 1'b0;
      adm_r <= STL_ADM_EN;
    end
    else if (wr && addr == STL_REG_PORT && !term_rej)
    begin
      if (wdata[STL_PORT_LB_START])
      begin
        lb_r <= 1'b1;
        adm_r <= STL_ADM_TEST;
      end
      else if (wdata[2:1] == 2'h0 || wdata[2:1] == 2'h1)
      begin
        lb_r <= 1'b0;
        adm_r <= stl_adm_t'(wdata[2:1]);
      end
    end
  end

  // Interrupt status: 0 alert, 1 log overflow, 2 refused loopback
  logic [2:0] irq_set;
  assign irq_set = {term_rej, log_push & log_full, log_push};
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      irq_stat_r <= '0;
    else
      irq_stat_r <= (irq_stat_r & ~((wr && addr == STL_REG_IRQ_STAT) ? wdata[2:0] : 3'h0))
                    | irq_set;
  end
  assign irq = |(irq_stat_r & irq_mask_r);

  // Transmit path
  logic [7:0] tx_nxt;
  always_comb
  begin
    tx_nxt = gen_byte;
    if (lb_r)
      tx_nxt = rx_byte;
    else
    begin
      if (ms_r == STL_MS_AIS && !byte_a1 && !byte_a2 && !byte_b1)
        tx_nxt = STL_CORRUPT;
      if (rs_r == STL_RS_B1 && byte_b1)
        tx_nxt = gen_byte ^ STL_CORRUPT;
      if (rs_r == STL_RS_LOF && (byte_a1 || byte_a2))
        tx_nxt = gen_byte ^ STL_CORRUPT;
      if (ms_r == STL_MS_B2 && byte_b2)
        tx_nxt = gen_byte ^ STL_CORRUPT;
    end
  end
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      tx_byte <= '0;
    else
      tx_byte <= tx_nxt;
  end
  assign ms_ais_tx = !lb_r && ms_r == STL_MS_AIS;
  assign client_ais = lb_r;
  assign eth_idle = lb_r;
  assign lb_active = lb_r;
  assign adm_state = adm_r;

  // Read port
  always_ff @(posedge clk)
  begin
    if (!rst_n || !rd)
      rdata_r <= '0;
    else
    begin
      rdata_r <= '0;
      unique case (addr)
        STL_REG_TCA_EN: rdata_r <= {28'h0, tca_en_r};
        STL_REG_PORT: rdata_r <= {29'h0, adm_r, lb_r};
        STL_REG_ERRINS: rdata_r <= {26'h0, ms_r, 2'h0, rs_r};
        STL_REG_IRQ_STAT: rdata_r <= {29'h0, irq_stat_r};
        STL_REG_IRQ_MASK: rdata_r <= {29'h0, irq_mask_r};
        STL_REG_LOG_STAT: rdata_r <= 32'({page_r, 16'h0}) | 32'(cnt_r);
        STL_REG_LOG_DATA: rdata_r <= (cnt_r != '0) ? {16'h0, log_mem[rp_r]} : '0;
        STL_REG_PAGE: rdata_r <= (age < cnt_r && {2'b0, wdata[LW-3:0]} < LW'(PAGE_LEN)) ?
          {16'h8000, log_mem[idx]} : '0;
        STL_REG_SEL: rdata_r <= {24'h0, sel_r};
        default: rdata_r <= '0;
      endcase
      for (int i = 0; i < STL_NCLASS; i++)
        if (addr == STL_REG_DEF_BASE + 8'(4 * i))
          rdata_r <= def_thr_r[i];
      for (int i = 0; i < NE; i++)
        if (addr == STL_REG_CUS_BASE + 8'(4 * i))
          rdata_r <= cus_thr_r[i];
    end
  end
  assign rdata = rdata_r;

  // Checks
  a_tca_reset_off: assert property (@(posedge clk) !rst_n |=> tca_en_r == 4'h0)
    else $error("alert enables not cleared by reset");
  a_log_clear: assert property (@(posedge clk) disable iff (!rst_n)
    log_clr |=> cnt_r == '0)
    else $error("log not empty after clear");
  a_log_bound: assert property (@(posedge clk) disable iff (!rst_n)
    cnt_r <= LW'(LOG_DEPTH))
    else $error("log exceeds depth");
  a_lb_start: assert property (@(posedge clk) disable iff (!rst_n)
    wr && addr == STL_REG_PORT && wdata[0] && !wdata[3] |=> lb_active && adm_state == 2'h2)
    else $error("loopback start not reflected");
  a_lb_stop: assert property (@(posedge clk) disable iff (!rst_n)
    wr && addr == STL_REG_PORT && wdata[3:0] == 4'h2 |=> !lb_active && adm_state == 2'h1)
    else $error("loopback not ended by disable");
  a_term_rej: assert property (@(posedge clk) disable iff (!rst_n)
    term_rej |=> $stable(lb_active))
    else $error("terminal loopback accepted");
  a_lb_clients: assert property (@(posedge clk) disable iff (!rst_n)
    lb_active |-> client_ais && eth_idle && !ms_ais_tx)
    else $error("clients not forced in loopback");
  a_lb_echo: assert property (@(posedge clk) disable iff (!rst_n)
    lb_active |=> tx_byte == $past(rx_byte))
    else $error("loopback not echoing line");
  a_b1_ins: assert property (@(posedge clk) disable iff (!rst_n)
    !lb_r && rs_r == STL_RS_B1 && byte_b1 |=> tx_byte == ($past(gen_byte) ^ STL_CORRUPT))
    else $error("B1 not corrupted");
  a_lof_ins: assert property (@(posedge clk) disable iff (!rst_n)
    !lb_r && rs_r == STL_RS_LOF && byte_a1 |=> tx_byte == ($past(gen_byte) ^ STL_CORRUPT))
    else $error("A1 not corrupted");
  a_b2_ins: assert property (@(posedge clk) disable iff (!rst_n)
    !lb_r && ms_r == STL_MS_B2 && byte_b2 |=> tx_byte == ($past(gen_byte) ^ STL_CORRUPT))
    else $error("B2 not corrupted");
  a_ms_ais_fill: assert property (@(posedge clk) disable iff (!rst_n)
    !lb_r && ms_r == STL_MS_AIS && !byte_a1 && !byte_a2 && !byte_b1 |=> tx_byte == 8'hff)
    else $error("MS-AIS not sent");
endmodule : stl_maint
`default_nettype wire

// >>> rtl/stl_pkg.sv
// Package for the line maintenance block: offsets, fields, reset values, timing
package stl_pkg;
  localparam int unsigned STL_CLK_HZ = 50000000;
  localparam int unsigned STL_P15_MIN = 15;
  localparam int unsigned STL_P24_HR = 24;
  localparam longint unsigned STL_P15_CYC = longint'(STL_P15_MIN) * 60 * STL_CLK_HZ;
  localparam longint unsigned STL_P24_CYC = longint'(STL_P24_HR) * 3600 * STL_CLK_HZ;
  localparam int unsigned STL_LOG_DEPTH = 500;
  localparam int unsigned STL_PAGE_LEN = 50;
  localparam int unsigned STL_NCLASS = 6;
  // Register offsets
  localparam logic [7:0] STL_REG_TCA_EN = 8'h00;
  localparam logic [7:0] STL_REG_PORT = 8'h04;
  localparam logic [7:0] STL_REG_ERRINS = 8'h08;
  localparam logic [7:0] STL_REG_IRQ_STAT = 8'h0c;
  localparam logic [7:0] STL_REG_IRQ_MASK = 8'h10;
  localparam logic [7:0] STL_REG_LOG_CTRL = 8'h14;
  localparam logic [7:0] STL_REG_LOG_STAT = 8'h18;
  localparam logic [7:0] STL_REG_LOG_DATA = 8'h1c;
  localparam logic [7:0] STL_REG_PAGE = 8'h20;
  localparam logic [7:0] STL_REG_DEF_BASE = 8'h40;
  localparam logic [7:0] STL_REG_CUS_BASE = 8'h60;
  localparam logic [7:0] STL_REG_SEL = 8'h80;
  // Field positions
  localparam int unsigned STL_PORT_LB_START = 0;
  localparam int unsigned STL_PORT_ADM_LO = 1;
  localparam int unsigned STL_PORT_TERM = 3;
  localparam int unsigned STL_LOG_CLR = 0;
  localparam int unsigned STL_LOG_PREV = 1;
  localparam int unsigned STL_LOG_NEXT = 2;
  localparam int unsigned STL_LOG_POP = 3;
  // Reset values
  localparam logic [31:0] STL_RST_THR = 32'h0000_000a;
  localparam logic [3:0] STL_RST_TCA_EN = 4'h0;
  // Framing bytes and the corruption mask
  localparam logic [7:0] STL_A1 = 8'hf6;
  localparam logic [7:0] STL_A2 = 8'h28;
  localparam logic [7:0] STL_CORRUPT = 8'hff;
  typedef enum logic [1:0] {STL_RS_OFF, STL_RS_B1, STL_RS_LOF} stl_rs_t;
  typedef enum logic [1:0] {STL_MS_OFF, STL_MS_B2, STL_MS_AIS} stl_ms_t;
  typedef enum logic [1:0] {STL_ADM_EN, STL_ADM_DIS, STL_ADM_TEST} stl_adm_t;
endpackage : stl_pkg

// >>> verification/stl_far_end.sv
// Far-end line equipment model: received byte source and frame alignment watch
`timescale 1ns/1ps
`default_nettype none
module stl_far_end
  import stl_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] tx_byte,
  input wire logic a1_mark,
  output logic [7:0] rx_byte,
  output logic lof_hit
);
  logic a1_d_r;
  // Line bytes change every cycle so a stale byte is seen
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      rx_byte <= 8'h5a;
    else
      rx_byte <= {rx_byte[6:0], rx_byte[7] ^ rx_byte[5] ^ rx_byte[4] ^ rx_byte[3]};
  end
  // Flags a framing byte that differs from the expected A1 value
  always_ff @(posedge clk)
  begin
    a1_d_r <= a1_mark;
    if (!rst_n)
      lof_hit <= 1'b0;
    else if (a1_d_r)
      lof_hit <= (tx_byte != STL_A1);
  end
endmodule : stl_far_end
`default_nettype wire

// >>> verification/stl_maint_tb.sv
// Self-checking bench for the line maintenance block
`timescale 1ns/1ps
`default_nettype none
module stl_maint_tb;
  import stl_pkg::*;
  logic clk, rst_n, wr, rd, irq, ms_ais_tx, client_ais, eth_idle, lb_active, lof_hit;
  logic byte_a1, byte_a2, byte_b1, byte_b2, cur_lb;
  logic [7:0] addr, rx_byte, gen_byte, tx_byte;
  logic [31:0] wdata, rdata;
  logic [5:0] ev_pulse;
  logic [2:0] ev_entity;
  logic [1:0] adm_state, cur_rs, cur_ms;
  int n_errors, cmp_count, seed, i, c, thr, cyc;

  stl_maint #(.P15_CYC(2000), .P24_CYC(6000)) uut (.clk(clk), .rst_n(rst_n), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq), .ev_pulse(ev_pulse),
    .ev_entity(ev_entity), .rx_byte(rx_byte), .gen_byte(gen_byte), .byte_a1(byte_a1),
    .byte_a2(byte_a2), .byte_b1(byte_b1), .byte_b2(byte_b2), .tx_byte(tx_byte),
    .ms_ais_tx(ms_ais_tx), .client_ais(client_ais), .eth_idle(eth_idle),
    .lb_active(lb_active), .adm_state(adm_state));
  stl_far_end far (.clk(clk), .rst_n(rst_n), .tx_byte(tx_byte), .a1_mark(byte_a1),
    .rx_byte(rx_byte), .lof_hit(lof_hit));

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) cyc <= rst_n ? cyc + 1 : 0;

  task automatic test_done;
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : test_done
  task automatic chk_v(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_v
  task automatic chk_f(input logic got, input logic exp);
    chk_v({31'h0, got}, {31'h0, exp});
  endtask : chk_f
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask : wr_reg
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    wdata <= 32'h0;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk_v(rdata, exp);
  endtask : rd_chk
  task automatic ev(input int k, input logic [2:0] e, input int n);
    repeat (n)
    begin
      @(posedge clk);
      ev_pulse <= 6'h1 << k;
      ev_entity <= e;
      @(posedge clk);
      ev_pulse <= 6'h0;
    end
    #1;
  endtask : ev
  function automatic logic [3:0] lay(input int k);
    return (k < 2) ? 4'(1 << k) : (k == 2) ? 4'h4 : 4'h8;
  endfunction : lay
  function automatic logic [7:0] exp_tx(input logic [3:0] p, input logic [7:0] g,
    input logic [7:0] r);
    logic [7:0] e;
    if (cur_lb)
      return r;
    e = g;
    if ((cur_rs == 2'h1 && p[2]) || (cur_rs == 2'h2 && p[1:0] != 2'h0))
      e = e ^ STL_CORRUPT;
    if (cur_ms == 2'h2 && p[2:0] == 3'h0)
      e = 8'hff;
    else if (cur_ms == 2'h1 && p[3])
      e = e ^ STL_CORRUPT;
    return e;
  endfunction : exp_tx
  task automatic send(input logic [3:0] p);
    logic [7:0] r;
    @(posedge clk);
    gen_byte <= p[0] ? STL_A1 : p[1] ? STL_A2 : 8'($random(seed));
    {byte_b2, byte_b1, byte_a2, byte_a1} <= p;
    @(negedge clk);
    r = rx_byte;
    @(posedge clk);
    #1;
    chk_v({24'h0, tx_byte}, {24'h0, exp_tx(p, gen_byte, r)});
  endtask : send

  initial
  begin
    repeat (20000) @(posedge clk);
    n_errors++;
    test_done();
  end
  initial
  begin
    seed = 74783;
    {rst_n, wr, rd, addr, wdata, ev_pulse, ev_entity, gen_byte} = '0;
    {byte_a1, byte_a2, byte_b1, byte_b2, cur_lb, cur_rs, cur_ms} = '0;
    n_errors = 0;
    cmp_count = 0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    rd_chk(STL_REG_TCA_EN, 32'h0);
    rd_chk(STL_REG_PORT, 32'h0);
    rd_chk(STL_REG_ERRINS, 32'h0);
    for (i = 0; i < 6; i++)
      rd_chk(STL_REG_DEF_BASE + 8'(4 * i), STL_RST_THR);
    rd_chk(8'hfc, 32'h0);
    wr_reg(STL_REG_IRQ_MASK, 32'h7);
    ev(0, 3'h0, 12);
    rd_chk(STL_REG_LOG_STAT, 32'h0);
    chk_f(irq, 1'b0);
    // Both periods restart before the layer sweep
    while (cyc < 6100) @(posedge clk);
    for (c = 0; c < 6; c++)
    begin
      thr = 2 + ($unsigned($random(seed)) % 4);
      wr_reg(STL_REG_DEF_BASE + 8'(4 * c), 32'(thr));
      wr_reg(STL_REG_TCA_EN, {28'h0, lay(c)});
      wr_reg(STL_REG_IRQ_STAT, 32'h7);
      ev(c, 3'h0, thr - 1);
      chk_f(irq, 1'b0);
      ev(c, 3'h0, 1);
      chk_f(irq, 1'b1);
      rd_chk(STL_REG_IRQ_STAT, 32'h1);
      wr_reg(STL_REG_IRQ_STAT, 32'h1);
      ev(c, 3'h0, 1);
      chk_f(irq, 1'b0);
    end
    // Six alerts logged, oldest class 0, newest class 5
    rd_chk(STL_REG_LOG_STAT, 32'h6);
    rd_chk(STL_REG_LOG_DATA, 32'h0);
    rd_chk(STL_REG_PAGE, 32'h8000_0005);
    wr_reg(STL_REG_LOG_CTRL, 32'h8);
    rd_chk(STL_REG_LOG_DATA, 32'h1);
    wr_reg(STL_REG_LOG_CTRL, 32'h2);
    rd_chk(STL_REG_LOG_STAT, 32'h5);
    // Next short period: custom threshold on one entity
    while (cyc < 8100) @(posedge clk);
    wr_reg(STL_REG_CUS_BASE + 8'h14, 32'h2);
    wr_reg(STL_REG_SEL, 32'h20);
    wr_reg(STL_REG_DEF_BASE + 8'h4, 32'h7);
    wr_reg(STL_REG_TCA_EN, 32'h2);
    wr_reg(STL_REG_LOG_CTRL, 32'h1);
    wr_reg(STL_REG_IRQ_STAT, 32'h7);
    ev(1, 3'h5, 1);
    chk_f(irq, 1'b0);
    ev(1, 3'h5, 1);
    chk_f(irq, 1'b1);
    rd_chk(STL_REG_PAGE, 32'h8000_0501);
    wr_reg(STL_REG_LOG_CTRL, 32'h1);
    rd_chk(STL_REG_LOG_STAT, 32'h0);
    // Loopback control
    wr_reg(STL_REG_IRQ_STAT, 32'h7);
    wr_reg(STL_REG_PORT, 32'h8);
    rd_chk(STL_REG_PORT, 32'h0);
    rd_chk(STL_REG_IRQ_STAT, 32'h4);
    wr_reg(STL_REG_ERRINS, 32'h20);
    wr_reg(STL_REG_PORT, 32'h1);
    rd_chk(STL_REG_PORT, 32'h5);
    chk_v({27'h0, lb_active, client_ais, eth_idle, adm_state}, 32'h1e);
    chk_f(ms_ais_tx, 1'b0);
    cur_lb = 1'b1;
    for (i = 0; i < 8; i++)
      send(4'h1 << ($unsigned($random(seed)) % 5));
    for (i = 1; i >= 0; i--)
    begin
      wr_reg(STL_REG_PORT, 32'(i << 1));
      rd_chk(STL_REG_PORT, 32'(i << 1));
      chk_v({29'h0, lb_active, client_ais, eth_idle}, 32'h0);
    end
    // Every selector pair, code 3 checked as behaving off
    cur_lb = 1'b0;
    for (c = 0; c < 16; c++)
    begin
      cur_rs = (c[1:0] == 2'h3) ? 2'h0 : c[1:0];
      cur_ms = (c[3:2] == 2'h3) ? 2'h0 : c[3:2];
      wr_reg(STL_REG_ERRINS, {26'h0, c[3:2], 2'h0, c[1:0]});
      chk_f(ms_ais_tx, cur_ms == 2'h2);
      send(4'h1);
      send(4'h0);
      chk_f(lof_hit, cur_rs == 2'h2);
      for (i = 0; i < 6; i++)
        send(4'h1 << ($unsigned($random(seed)) % 5));
    end
    test_done();
  end
endmodule : stl_maint_tb
`default_nettype wire
